// File: spisc_pkg.sv
// spisc_pkg: register map, field positions and shared types of the serial port
package spisc_pkg;

  // register indices on the cpu register port
  localparam logic [1:0] REG_CR = 2'h0;
  localparam logic [1:0] REG_SR = 2'h1;
  localparam logic [1:0] REG_DR = 2'h2;

  // control_reg fields
  localparam int CR_IRQ_ENABLE   = 7;
  localparam int CR_PORT_ENABLE  = 6;
  localparam int CR_DIV_OFF      = 5;
  localparam int CR_MASTER_SEL   = 4;
  localparam int CR_IDLE_LEVEL   = 3;
  localparam int CR_EDGE_PHASE   = 2;
  localparam int CR_RATE_HIGH    = 1;
  localparam int CR_RATE_LOW     = 0;
  localparam logic [7:0] CR_RESET = 8'h00;

  // status_reg fields
  localparam int SR_DONE_FLAG   = 7;
  localparam int SR_CLASH_FLAG  = 6;
  localparam int SR_FAULT_FLAG  = 4;
  localparam logic [7:0] SR_RESET = 8'h00;

  // master half periods in clk_sys cycles, per serial clock divider
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  // serial clock edges per byte: eight pulses, two edges each
  localparam logic [3:0] LAST_EDGE = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN  = 2'b10,
    ST_TAIL = 2'b11
  } spisc_state_t;

  // {div_off, rate_high, rate_low} to half period; unlisted codes take the slowest
  function automatic logic [6:0] rateHalf(input logic [2:0] sel);
    case (sel)
      3'h4:    rateHalf = HALF_DIV4;
      3'h0:    rateHalf = HALF_DIV8;
      3'h1:    rateHalf = HALF_DIV16;
      3'h6:    rateHalf = HALF_DIV32;
      3'h2:    rateHalf = HALF_DIV64;
      default: rateHalf = HALF_DIV128;
    endcase
  endfunction

endpackage

// File: spisc_if.sv
// spisc_if: serial link between the peripheral and the far end, with pin resolution
`timescale 1ns/100ps
interface spisc_if;
  // peripheral drives
  logic devSckO;
  logic devSckOe;
  logic devMosiO;
  logic devMosiOe;
  logic devMisoO;
  logic devMisoOe;
  // far end drives
  logic farSckO;
  logic farSckOe;
  logic farMosiO;
  logic farMosiOe;
  logic farSsnO;
  // resolved wire levels
  logic sck;
  logic mosi;
  logic miso;
  logic ssn;

  // undriven lines read as pulled: clock low, data high
  assign sck  = devSckOe ? devSckO : (farSckOe ? farSckO : 1'b0);
  assign mosi = devMosiOe ? devMosiO : (farMosiOe ? farMosiO : 1'b1);
  assign miso = devMisoOe ? devMisoO : 1'b1;
  assign ssn  = farSsnO;

  modport dev (
    output devSckO,
    output devSckOe,
    output devMosiO,
    output devMosiOe,
    output devMisoO,
    output devMisoOe,
    input  sck,
    input  mosi,
    input  miso,
    input  ssn
  );

  modport far (
    output farSckO,
    output farSckOe,
    output farMosiO,
    output farMosiOe,
    output farSsnO,
    input  sck,
    input  mosi,
    input  miso,
    input  ssn
  );
endinterface

// File: spisc_sync.sv
// spisc_sync: two flip-flop synchroniser for pin and cross-domain levels
`timescale 1ns/100ps
module spisc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // system
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else if (clkEn)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
endmodule

// File: spisc_far.sv
// spisc_far: external party, a master that makes the serial clock by a divider
`timescale 1ns/100ps
module spisc_far #(
  parameter logic [6:0] HALF = 7'h03
) (
  // system
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  // user request
  input  wire logic       startReq,
  input  wire logic [7:0] txByte,
  input  wire logic       idleLevel,
  input  wire logic       edgePhase,
  input  wire logic       holdSel,
  input  wire logic       drvEn,
  // user answer
  output logic      [7:0] rxByte,
  output logic            doneP,
  output logic            busy,
  // serial link
  spisc_if.far            link
);
  spisc_pkg::spisc_state_t state_r;
  logic [6:0] halfCnt_r;
  logic [3:0] edgeIdx_r;
  logic       sck_r;
  logic       ssn_r;
  logic       capBit_r;
  logic [7:0] sh_r;
  logic       misoS;
  logic       tick;

  spisc_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
    .clk   (clk_sys),
    .rstn  (rstn),
    .clkEn (clkEn),
    .d     (link.miso),
    .q     (misoS)
  );

  assign tick          = (halfCnt_r == HALF - 7'h01);
  assign busy          = (state_r != spisc_pkg::ST_IDLE);
  assign link.farSckO  = sck_r;
  assign link.farSckOe = drvEn;
  assign link.farMosiO = sh_r[7];
  assign link.farMosiOe = drvEn;
  assign link.farSsnO  = ssn_r;

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      state_r   <= spisc_pkg::ST_IDLE;
      halfCnt_r <= 7'h00;
      edgeIdx_r <= 4'h0;
      sck_r     <= 1'b0;
      ssn_r     <= 1'b1;
      capBit_r  <= 1'b0;
      sh_r      <= 8'h00;
      rxByte    <= 8'h00;
      doneP     <= 1'b0;
    end
    else if (clkEn)
    begin
      doneP <= 1'b0;
      case (state_r)
        spisc_pkg::ST_IDLE:
        begin
          sck_r     <= idleLevel;
          halfCnt_r <= 7'h00;
          edgeIdx_r <= 4'h0;
          if (startReq)
          begin
            sh_r    <= txByte;
            ssn_r   <= 1'b0;
            state_r <= spisc_pkg::ST_LEAD;
          end
        end
        spisc_pkg::ST_LEAD:
        begin
          halfCnt_r <= tick ? 7'h00 : halfCnt_r + 7'h01;
          if (tick)
            state_r <= spisc_pkg::ST_RUN;
        end
        spisc_pkg::ST_RUN:
        begin
          halfCnt_r <= tick ? 7'h00 : halfCnt_r + 7'h01;
          if (tick)
          begin
            sck_r     <= ~sck_r;
            edgeIdx_r <= edgeIdx_r + 4'h1;
            if (edgeIdx_r[0] == edgePhase)
              capBit_r <= misoS;
            else if (edgeIdx_r != 4'h0 || !edgePhase)
              sh_r <= {sh_r[6:0], capBit_r};
            if (edgeIdx_r == spisc_pkg::LAST_EDGE)
            begin
              rxByte  <= {sh_r[6:0], edgePhase ? misoS : capBit_r};
              doneP   <= 1'b1;
              state_r <= spisc_pkg::ST_TAIL;
            end
          end
        end
        spisc_pkg::ST_TAIL:
        begin
          halfCnt_r <= tick ? 7'h00 : halfCnt_r + 7'h01;
          if (tick)
          begin
            // select may stay low only in second-edge phase
            if (ssn_r || !(edgePhase && holdSel))
              ssn_r <= 1'b1;
            if (ssn_r || (edgePhase && holdSel))
              state_r <= spisc_pkg::ST_IDLE;
          end
        end
        default: state_r <= spisc_pkg::ST_IDLE;
      endcase
    end
endmodule

// File: spisc_dev.sv
// spisc_dev: serial peripheral port, cpu register side plus master and slave engines
// Function
// - done flag clears: status access, then data read
// - data writes ignored while done flag unacknowledged
// - rate bits unused in slave mode
// - slave shifts written byte out, msb first
// - slave transfer starts on master's clock
// - byte end sets done flag, interrupt request
// - last edge copies received byte to buffer
// - full duplex, exactly eight clock pulses
// - polarity bit sets clock idle level
// - phase set: capture on second edge
// - phase clear: capture on first edge
// - master toggles select between bytes, phase clear
// - low select locks data register
// - write during transfer discarded, transfer continues
// - collision sets flag, no interrupt
// - phase set: first edge drives msb
// - master write while shifting is collision
// - master's select input held high
// - select low in master: fault, drop enables
// - fault clears: status access, then control write
// - enables refused while fault flag unacknowledged
// - overrun keeps first byte, no indication
`timescale 1ns/100ps
module spisc_dev (
  // system
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  // cpu register port
  input  wire logic [1:0] regAddr,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       cpuIntMask,
  output logic            irqReq,
  // serial link
  input  wire logic       sckLink,
  spisc_if.dev            link
);
  logic [7:0] crReg_r;
  logic       doneFlag_r;
  logic       clashFlag_r;
  logic       faultFlag_r;
  logic       doneArm_r;
  logic       clashArm_r;
  logic       faultArm_r;
  logic [7:0] dataReg_r;
  logic [7:0] rxBuf_r;
  spisc_pkg::spisc_state_t mstState_r;
  logic [6:0] halfCnt_r;
  logic [3:0] edgeIdx_r;
  logic       sckOut_r;
  logic       capBit_r;
  logic [7:0] mstSh_r;
  logic       doneSeen_r;
  // link-domain state
  logic [7:0] rxSh_r;
  logic [2:0] bitCnt_r;
  logic [7:0] rxHold_r;
  logic       doneTgl_r;
  logic [2:0] outIdx_r;
  logic       outOn_r;

  logic ssnS;
  logic misoS;
  logic doneTglS;
  logic isMaster;
  logic portEn;
  logic idleLevel;
  logic edgePhase;
  logic slvEn;
  logic srAcc;
  logic drRd;
  logic drWr;
  logic crWr;
  logic drWrTake;
  logic clash;
  logic drLoad;
  logic mstRun;
  logic mstTick;
  logic mstDone;
  logic slvDone;
  logic byteDone;
  logic [7:0] newByte;
  logic doneClr;
  logic faultEv;
  logic capClk;
  logic linkRstn;

  spisc_sync #(.W(3), .RST_VAL(3'b110)) u_sync (
    .clk   (clk_sys),
    .rstn  (rstn),
    .clkEn (clkEn),
    .d     ({link.ssn, link.miso, doneTgl_r}),
    .q     ({ssnS, misoS, doneTglS})
  );

  assign isMaster  = crReg_r[spisc_pkg::CR_MASTER_SEL];
  assign portEn    = crReg_r[spisc_pkg::CR_PORT_ENABLE];
  assign idleLevel = crReg_r[spisc_pkg::CR_IDLE_LEVEL];
  assign edgePhase = crReg_r[spisc_pkg::CR_EDGE_PHASE];
  assign slvEn     = portEn & ~isMaster;

  assign srAcc = (regRd | regWr) && (regAddr == spisc_pkg::REG_SR);
  assign drRd  = regRd && (regAddr == spisc_pkg::REG_DR);
  assign drWr  = regWr && (regAddr == spisc_pkg::REG_DR);
  assign crWr  = regWr && (regAddr == spisc_pkg::REG_CR);

  assign mstRun   = (mstState_r == spisc_pkg::ST_RUN);
  assign drWrTake = drWr && !(doneFlag_r && !doneArm_r);
  // slave collides whenever selected, the far master may clock at any moment
  assign clash    = drWrTake && (mstRun || (slvEn && !ssnS));
  assign drLoad   = drWrTake && !clash;

  assign faultEv  = isMaster && !ssnS;
  // only the three rate bits pick the divider; the phase bit must stay out of the selector
  assign mstTick  = mstRun && (halfCnt_r == spisc_pkg::rateHalf({crReg_r[spisc_pkg::CR_DIV_OFF],
                    crReg_r[spisc_pkg::CR_RATE_HIGH], crReg_r[spisc_pkg::CR_RATE_LOW]}) - 7'h01);
  assign mstDone  = mstTick && (edgeIdx_r == spisc_pkg::LAST_EDGE) && !faultEv;
  assign slvDone  = doneTglS ^ doneSeen_r;
  assign byteDone = mstDone || slvDone;
  assign newByte  = mstDone ? {mstSh_r[6:0], edgePhase ? misoS : capBit_r} : rxHold_r;
  assign doneClr  = drRd && doneArm_r;

  assign irqReq = crReg_r[spisc_pkg::CR_IRQ_ENABLE] & (doneFlag_r | faultFlag_r) & ~cpuIntMask;

  assign link.devSckO    = sckOut_r;
  assign link.devSckOe   = portEn & isMaster;
  assign link.devMosiO   = mstSh_r[7];
  assign link.devMosiOe  = portEn & isMaster;
  assign link.devMisoO   = dataReg_r[~outIdx_r];
  assign link.devMisoOe  = slvEn & ~link.ssn & (~edgePhase | outOn_r);

  // control register with fault overrides
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      crReg_r <= spisc_pkg::CR_RESET;
    else if (clkEn)
    begin
      if (crWr)
      begin
        crReg_r <= regWdata;
        if (faultFlag_r && !faultArm_r)
        begin
          crReg_r[spisc_pkg::CR_PORT_ENABLE] <= 1'b0;
          crReg_r[spisc_pkg::CR_MASTER_SEL]  <= 1'b0;
        end
      end
      if (faultEv)
      begin
        crReg_r[spisc_pkg::CR_PORT_ENABLE] <= 1'b0;
        crReg_r[spisc_pkg::CR_MASTER_SEL]  <= 1'b0;
      end
    end

  // status flags and their two-step clearing; a set wins over a clear
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      doneFlag_r  <= 1'b0;
      clashFlag_r <= 1'b0;
      faultFlag_r <= 1'b0;
      doneArm_r   <= 1'b0;
      clashArm_r  <= 1'b0;
      faultArm_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      if (byteDone)
        doneFlag_r <= 1'b1;
      else if (doneClr)
        doneFlag_r <= 1'b0;
      if (byteDone || doneClr)
        doneArm_r <= 1'b0;
      else if (srAcc && doneFlag_r)
        doneArm_r <= 1'b1;
      if (clash)
        clashFlag_r <= 1'b1;
      else if (clashArm_r && (drRd || drWr))
        clashFlag_r <= 1'b0;
      if (clash || (clashArm_r && (drRd || drWr)))
        clashArm_r <= 1'b0;
      else if (regRd && regAddr == spisc_pkg::REG_SR && clashFlag_r)
        clashArm_r <= 1'b1;
      if (faultEv)
        faultFlag_r <= 1'b1;
      else if (crWr && faultArm_r)
        faultFlag_r <= 1'b0;
      if (faultEv || crWr)
        faultArm_r <= 1'b0;
      else if (srAcc && faultFlag_r)
        faultArm_r <= 1'b1;
    end

  // data register, receive buffer and register read port
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      dataReg_r  <= 8'h00;
      rxBuf_r    <= 8'h00;
      regRdata   <= 8'h00;
      doneSeen_r <= 1'b0;
    end
    else if (clkEn)
    begin
      doneSeen_r <= doneTglS;
      if (drLoad)
        dataReg_r <= regWdata;
      // only the first byte after a clear is kept, later ones are dropped silently
      if (byteDone && (!doneFlag_r || doneClr))
        rxBuf_r <= newByte;
      if (regRd)
      begin
        case (regAddr)
          spisc_pkg::REG_CR: regRdata <= crReg_r;
          spisc_pkg::REG_SR: regRdata <= {doneFlag_r, clashFlag_r, 1'b0, faultFlag_r, 4'h0};
          spisc_pkg::REG_DR: regRdata <= rxBuf_r;
          default:           regRdata <= 8'h00;
        endcase
      end
    end

  // master engine: serial clock from the rate divider
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      mstState_r <= spisc_pkg::ST_IDLE;
      halfCnt_r  <= 7'h00;
      edgeIdx_r  <= 4'h0;
      sckOut_r   <= 1'b0;
      capBit_r   <= 1'b0;
      mstSh_r    <= 8'h00;
    end
    else if (clkEn)
    begin
      case (mstState_r)
        spisc_pkg::ST_IDLE:
        begin
          sckOut_r  <= idleLevel;
          halfCnt_r <= 7'h00;
          edgeIdx_r <= 4'h0;
          if (drLoad && isMaster && portEn)
          begin
            mstSh_r    <= regWdata;
            mstState_r <= spisc_pkg::ST_RUN;
          end
        end
        spisc_pkg::ST_RUN:
        begin
          if (faultEv)
            mstState_r <= spisc_pkg::ST_IDLE;
          else if (mstTick)
          begin
            halfCnt_r <= 7'h00;
            sckOut_r  <= ~sckOut_r;
            edgeIdx_r <= edgeIdx_r + 4'h1;
            if (edgeIdx_r[0] == edgePhase)
              capBit_r <= misoS;
            else if (edgeIdx_r != 4'h0 || !edgePhase)
              mstSh_r <= {mstSh_r[6:0], capBit_r};
            if (edgeIdx_r == spisc_pkg::LAST_EDGE)
            begin
              mstSh_r    <= newByte;
              mstState_r <= spisc_pkg::ST_IDLE;
            end
          end
          else
            halfCnt_r <= halfCnt_r + 7'h01;
        end
        default: mstState_r <= spisc_pkg::ST_IDLE;
      endcase
    end

  // slave engine on the link clock; mode bits are only changed while deselected
  assign capClk   = sckLink ^ (idleLevel ^ edgePhase);
  assign linkRstn = rstn & ~link.ssn & slvEn;

  always_ff @(posedge capClk or negedge linkRstn)
    if (!linkRstn)
    begin
      rxSh_r   <= 8'h00;
      bitCnt_r <= 3'h0;
    end
    else
    begin
      rxSh_r   <= {rxSh_r[6:0], link.mosi};
      bitCnt_r <= bitCnt_r + 3'h1;
    end

  // toggle and held byte survive deselect: select may rise before the system side takes the byte
  always_ff @(posedge capClk or negedge rstn)
    if (!rstn)
    begin
      doneTgl_r <= 1'b0;
      rxHold_r  <= 8'h00;
    end
    else if (linkRstn && bitCnt_r == 3'h7)
    begin
      doneTgl_r <= ~doneTgl_r;
      rxHold_r  <= {rxSh_r[6:0], link.mosi};
    end

  always_ff @(negedge capClk or negedge linkRstn)
    if (!linkRstn)
    begin
      outIdx_r <= 3'h0;
      outOn_r  <= 1'b0;
    end
    else
    begin
      outIdx_r <= bitCnt_r;
      outOn_r  <= 1'b1;
    end
endmodule

// File: spisc_asserts.sv
// spisc_asserts: concurrent checks on the serial link between the two ends
`timescale 1ns/100ps
module spisc_asserts (
  // system
  input  wire logic clk_sys,
  input  wire logic rstn,
  // drive enables
  input  wire logic devSckOe,
  input  wire logic devMosiOe,
  input  wire logic devMisoOe,
  input  wire logic farSckOe,
  input  wire logic farMosiOe,
  // resolved lines
  input  wire logic sck,
  input  wire logic ssn
);
  logic       sckPrev_r;
  logic [4:0] edgeCnt_r;
  logic [4:0] edgeCnt_nxt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // counted only while selected, so master traffic with select high is ignored
  assign edgeCnt_nxt = ssn ? 5'h00 : edgeCnt_r + {4'h0, sck ^ sckPrev_r};

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      sckPrev_r <= 1'b0;
    else
      sckPrev_r <= sck;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      edgeCnt_r <= 5'h00;
    else
      edgeCnt_r <= edgeCnt_nxt;
  end

  chk_sck_one_driver: assert property (devSckOe |-> !farSckOe)
    else $error("serial clock driven by both ends");
  chk_mosi_one_driver: assert property (devMosiOe |-> !farMosiOe)
    else $error("master data line driven by both ends");
  chk_pins_exclusive: assert property (devMisoOe |-> !devMosiOe && !devSckOe)
    else $error("slave output driven together with master pins");
  chk_miso_released: assert property (ssn && $past(ssn) && $past(ssn, 2) && $past(ssn, 3) |-> !devMisoOe)
    else $error("slave output driven while not selected");
  chk_fault_sck_off: assert property ($fell(ssn) && devSckOe |-> ##[1:5] !devSckOe)
    else $error("serial clock kept driven after mode fault");
  chk_fault_mosi_off: assert property ($fell(ssn) && devMosiOe |-> ##[1:5] !devMosiOe)
    else $error("master data line kept driven after mode fault");
  chk_byte_edges: assert property ($rose(ssn) |-> edgeCnt_r[3:0] == 4'h0)
    else $error("frame did not hold whole bytes of sixteen clock edges");
  chk_tail_quiet: assert property ($rose(ssn) |-> $stable(sck) [*3])
    else $error("serial clock left its idle level after the frame");
endmodule

// File: test_spi_slave_collision_fault.sv
// test_spi_slave_collision_fault: bench joining the peripheral and the far master
`timescale 1ns/100ps
module test_spi_slave_collision_fault;
  logic       clk_sys;
  logic       rstn;
  logic [1:0] regAddr;
  logic       regWr;
  logic       regRd;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       cpuIntMask;
  logic       irqReq;
  logic       startReq;
  logic [7:0] txByte;
  logic       idleLevel;
  logic       edgePhase;
  logic       drvEn;
  logic       holdSel;
  logic [7:0] rxByte;
  logic       doneP;
  logic       busy;
  int         miscompares;
  int         testsRun;
  int         cycles;
  logic       rdSeen;
  logic [7:0] rdQ[$];
  logic [7:0] farQ[$];
  logic [7:0] devB;
  logic [7:0] farB;
  logic [1:0] modeV;
  logic [31:0] seedV;

  spisc_if i_spisc_if ();
  spisc_dev i_spisc_dev (.clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .cpuIntMask(cpuIntMask), .irqReq(irqReq),
    .sckLink(i_spisc_if.sck), .link(i_spisc_if.dev));
  spisc_far #(.HALF(7'h03)) i_spisc_far (.clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1), .startReq(startReq),
    .txByte(txByte), .idleLevel(idleLevel), .edgePhase(edgePhase), .holdSel(holdSel), .drvEn(drvEn),
    .rxByte(rxByte), .doneP(doneP), .busy(busy), .link(i_spisc_if.far));
  spisc_asserts i_spisc_asserts (.clk_sys(clk_sys), .rstn(rstn), .devSckOe(i_spisc_if.devSckOe),
    .devMosiOe(i_spisc_if.devMosiOe), .devMisoOe(i_spisc_if.devMisoOe), .farSckOe(i_spisc_if.farSckOe),
    .farMosiOe(i_spisc_if.farMosiOe), .sck(i_spisc_if.sck), .ssn(i_spisc_if.ssn));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatched %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic regAcc(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    regAddr  = a;
    regWdata = d;
    regWr    = wr;
    regRd    = !wr;
    @(posedge clk_sys);
    #1;
    regWr = 1'b0;
    regRd = 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    rdQ.push_back(exp);
    regAcc(1'b0, a, 8'h00);
  endtask

  task automatic farStart(input logic [7:0] b, input logic [7:0] exp);
    farQ.push_back(exp);
    @(posedge clk_sys);
    #1;
    txByte   = b;
    startReq = 1'b1;
    @(posedge clk_sys);
    #1;
    startReq = 1'b0;
  endtask

  // bounded so a stuck far end falls through to the next step after 300 cycles
  task automatic farWait;
    for (int i = 0; i < 300 && busy !== 1'b0; i++)
      @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys)
  begin
    if (rdSeen === 1'b1)
      check(regRdata, rdQ.pop_front());
    if (doneP === 1'b1)
      check(rxByte, farQ.pop_front());
    rdSeen <= regRd;
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      miscompares++;
      stop_test;
    end
  end

  initial
  begin
    rstn = 1'b0;
    {regAddr, regWr, regRd, regWdata, cpuIntMask, startReq, txByte} = '0;
    {idleLevel, edgePhase, holdSel, rdSeen, miscompares, testsRun, cycles} = '0;
    drvEn = 1'b1;
    seedV = $urandom(32'h9035);
    devB  = 8'($urandom);
    repeat (3) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    rd(spisc_pkg::REG_CR, spisc_pkg::CR_RESET);
    rd(spisc_pkg::REG_SR, spisc_pkg::SR_RESET);
    rd(2'h3, 8'h00);
    $display("test reset values done");
    for (int m = 0; m < 4; m++)
    begin
      modeV = m[1:0];
      farB  = 8'($urandom);
      {idleLevel, edgePhase} = modeV;
      // random rate bits must not matter to a slave
      regAcc(1'b1, spisc_pkg::REG_CR, 8'h40 | {4'h0, modeV, 2'($urandom)});
      // loaded once, so each later frame shows the refused write left it alone
      if (m == 0)
        regAcc(1'b1, spisc_pkg::REG_DR, devB);
      farStart(farB, devB);
      farWait;
      regAcc(1'b1, spisc_pkg::REG_DR, ~devB);
      rd(spisc_pkg::REG_SR, 8'h80);
      rd(spisc_pkg::REG_DR, farB);
      rd(spisc_pkg::REG_SR, 8'h00);
    end
    $display("test slave modes done");
    {idleLevel, edgePhase} = 2'b00;
    regAcc(1'b1, spisc_pkg::REG_CR, 8'hC0);
    regAcc(1'b1, spisc_pkg::REG_DR, devB);
    farStart(farB, devB);
    repeat (8) @(posedge clk_sys);
    regAcc(1'b1, spisc_pkg::REG_DR, ~devB);
    check({7'h00, irqReq}, 8'h00);
    farWait;
    check({7'h00, irqReq}, 8'h01);
    cpuIntMask = 1'b1;
    #1;
    check({7'h00, irqReq}, 8'h00);
    cpuIntMask = 1'b0;
    // the clashing write was discarded, so the old byte goes out again
    farStart(~farB, devB);
    farWait;
    rd(spisc_pkg::REG_SR, 8'hC0);
    rd(spisc_pkg::REG_DR, farB);
    rd(spisc_pkg::REG_SR, 8'h00);
    $display("test collision and overrun done");
    drvEn = 1'b0;
    regAcc(1'b1, spisc_pkg::REG_CR, 8'h70);
    regAcc(1'b1, spisc_pkg::REG_DR, devB);
    repeat (10) @(posedge clk_sys);
    regAcc(1'b1, spisc_pkg::REG_DR, farB);
    repeat (40) @(posedge clk_sys);
    rd(spisc_pkg::REG_SR, 8'hC0);
    rd(spisc_pkg::REG_DR, 8'hFF);
    rd(spisc_pkg::REG_SR, 8'h00);
    $display("test master collision done");
    regAcc(1'b1, spisc_pkg::REG_CR, 8'hD0);
    // select held high until now keeps the master legal
    farStart(8'h00, 8'hFF);
    farWait;
    check({7'h00, irqReq}, 8'h01);
    rd(spisc_pkg::REG_CR, 8'h80);
    regAcc(1'b1, spisc_pkg::REG_CR, 8'h50);
    rd(spisc_pkg::REG_CR, 8'h00);
    rd(spisc_pkg::REG_SR, 8'h10);
    regAcc(1'b1, spisc_pkg::REG_CR, 8'h50);
    rd(spisc_pkg::REG_SR, 8'h00);
    rd(spisc_pkg::REG_CR, 8'h50);
    $display("test mode fault done");
    // second-edge phase lets select stay low across two bytes
    {idleLevel, edgePhase, holdSel} = 3'b011;
    regAcc(1'b1, spisc_pkg::REG_CR, 8'h44);
    drvEn = 1'b1;
    farStart(farB, devB);
    farWait;
    farStart(~farB, devB);
    holdSel = 1'b0;
    farWait;
    rd(spisc_pkg::REG_SR, 8'h80);
    rd(spisc_pkg::REG_DR, farB);
    rd(spisc_pkg::REG_SR, 8'h00);
    $display("test held select done");
    repeat (3) @(posedge clk_sys);
    stop_test;
  end
endmodule
